// ---- verilog/cep_pkg.sv ----
// Constants shared by both ends of the configuration EEPROM serial program port
package cep_pkg;
  localparam int CLK_NS = 20;
  localparam int T_SCL_NS = 320; // Serial clock period made by the programmer
  localparam int QTR_CYC = T_SCL_NS / CLK_NS / 4;
  localparam int T_WR_US = 5000; // Longest self-timed write
  localparam int WR_CYC_DEF = T_WR_US * 1000 / CLK_NS;
  localparam int ADDR_W = 17;
  localparam int MEM_BYTES = 1 << ADDR_W;
  localparam int OFF_W = 7;
  localparam int LEN_W = 18;
  localparam logic [7:0] PAGE_BYTES = 8'h80;
  localparam logic [OFF_W-1:0] OFF_ONE = 7'h01;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 17'h00001;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [6:0] DEV_SEL = 7'h50; // Device select code, value arbitrary
  localparam logic [6:0] PAD_ADDR = 7'h00;

  // Reverse bit order of a byte
  function automatic logic [7:0] cep_rev8(input logic [7:0] b);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = b[7-i];
    end
    return r;
  endfunction
endpackage

// ---- verilog/cep_link_if.sv ----
// Two-wire link between programmer and configuration EEPROM
`timescale 1ns/10ps
interface cep_link_if;
  logic program_mode_select_n;
  logic cfg_serial_clock_line;
  logic prg_sda_o;
  logic prg_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic cfg_serial_data_line;

  // Open-drain data line with pull-up
  assign cfg_serial_data_line = !((prg_sda_oe && !prg_sda_o) || (dev_sda_oe && !dev_sda_o));

  modport dev(input program_mode_select_n, input cfg_serial_clock_line,
              input cfg_serial_data_line, output dev_sda_o, output dev_sda_oe);
  modport prg(output program_mode_select_n, output cfg_serial_clock_line,
              output prg_sda_o, output prg_sda_oe, input cfg_serial_data_line);
endinterface

// ---- verilog/cep_dev.sv ----
// Configuration EEPROM end of the two-wire program port
`timescale 1ns/10ps
module cep_dev import cep_pkg::*; #(
  parameter int WR_CYCLES = WR_CYC_DEF
) (
  // System
  input wire logic clk,
  input wire logic reset,
  // Link
  cep_link_if.dev link,
  // Status
  output logic busy,
  output logic [ADDR_W-1:0] cur_addr
);
  typedef enum logic [2:0] {S_IDLE, S_DEV, S_ADDR, S_WDATA, S_RDATA, S_IGN, S_WRCYC} cep_dst_t;

  logic [2:0] s1_ff, s2_ff, s3_ff;
  cep_dst_t st_ff, nxt_st;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] sh_ff, nxt_sh, tx_ff, nxt_tx, cmt_ff, nxt_cmt, byte_in;
  logic oe_ff, nxt_oe, ack_ff, nxt_ack, lim_ff, nxt_lim, wseen_ff, nxt_wseen, busy_ff;
  logic [ADDR_W-1:0] cur_ff, nxt_cur, wa_ff, nxt_wa;
  logic [1:0] acnt_ff, nxt_acnt;
  logic [15:0] abuf_ff, nxt_abuf;
  logic [OFF_W-1:0] lastw_ff, nxt_lastw;
  logic [PAGE_BYTES-1:0] pv_ff, nxt_pv;
  logic [31:0] tmr_ff, nxt_tmr;
  logic pb_we, mem_we;
  logic [7:0] pbuf [PAGE_BYTES];
  logic [7:0] mem [MEM_BYTES];
  logic scl_rise, scl_fall, start_c, stop_c, mode_on, sda;

  // Two-stage synchronisers for select, clock and data, plus an edge stage
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_ff <= 3'h7;
      s2_ff <= 3'h7;
      s3_ff <= 3'h7;
    end else begin
      s1_ff <= {link.program_mode_select_n, link.cfg_serial_clock_line,
                link.cfg_serial_data_line};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Line events
  assign sda = s2_ff[0];
  assign scl_rise = s2_ff[1] & ~s3_ff[1];
  assign scl_fall = ~s2_ff[1] & s3_ff[1];
  assign start_c = s2_ff[1] & s3_ff[1] & s3_ff[0] & ~s2_ff[0];
  assign stop_c = s2_ff[1] & s3_ff[1] & ~s3_ff[0] & s2_ff[0];
  assign mode_on = ~s2_ff[2];
  assign byte_in = {sh_ff[6:0], sda};

  // Protocol engine next state
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_tx = tx_ff;
    nxt_cmt = cmt_ff;
    nxt_oe = oe_ff;
    nxt_ack = ack_ff;
    nxt_lim = lim_ff;
    nxt_wseen = wseen_ff;
    nxt_cur = cur_ff;
    nxt_wa = wa_ff;
    nxt_acnt = acnt_ff;
    nxt_abuf = abuf_ff;
    nxt_lastw = lastw_ff;
    nxt_pv = pv_ff;
    nxt_tmr = tmr_ff;
    pb_we = 1'b0;
    mem_we = 1'b0;
    if (st_ff == S_WRCYC) begin
      // Link ignored; page committed one byte a cycle, then timer ends cycle
      nxt_oe = 1'b0;
      if (cmt_ff != PAGE_BYTES) begin
        mem_we = pv_ff[cmt_ff[OFF_W-1:0]];
        nxt_cmt = cmt_ff + 8'h01;
      end
      nxt_tmr = tmr_ff - 32'h1;
      if (tmr_ff == 32'h0) begin
        nxt_st = S_IDLE;
        nxt_pv = '0;
      end
    end else if (!mode_on) begin
      nxt_st = S_IDLE;
      nxt_oe = 1'b0;
    end else if (start_c) begin
      nxt_st = S_DEV;
      nxt_cnt = 4'h0;
      nxt_oe = 1'b0;
    end else if (stop_c) begin
      nxt_oe = 1'b0;
      nxt_st = S_IDLE;
      if (st_ff == S_WDATA && wseen_ff) begin
        nxt_st = S_WRCYC;
        nxt_tmr = 32'(WR_CYCLES);
        nxt_cmt = 8'h00;
        nxt_cur = {wa_ff[ADDR_W-1:OFF_W], lastw_ff} + ADDR_ONE;
      end
    end else if (scl_rise) begin
      if (cnt_ff != ACK_BIT) begin
        nxt_sh = byte_in;
        nxt_cnt = cnt_ff + 4'h1;
        if (cnt_ff == LAST_BIT) begin
          nxt_ack = 1'b1;
          case (st_ff)
            S_DEV: begin
              if (byte_in[7:1] != DEV_SEL) begin
                nxt_st = S_IGN;
                nxt_ack = 1'b0;
              end else if (byte_in[0]) begin
                nxt_st = S_RDATA;
                nxt_tx = mem[cur_ff];
                nxt_lim = 1'b0;
              end else begin
                nxt_st = S_ADDR;
                nxt_acnt = 2'h0;
              end
            end
            S_ADDR: begin
              nxt_acnt = acnt_ff + 2'h1;
              if (acnt_ff == 2'h0) begin
                nxt_abuf[15:8] = byte_in;
              end else if (acnt_ff == 2'h1) begin
                nxt_abuf[7:0] = byte_in;
              end else begin
                nxt_wa = ADDR_W'({abuf_ff, byte_in});
                nxt_cur = ADDR_W'({abuf_ff, byte_in});
                nxt_st = S_WDATA;
                nxt_wseen = 1'b0;
                nxt_pv = '0;
              end
            end
            S_WDATA: begin
              pb_we = 1'b1;
              nxt_pv[wa_ff[OFF_W-1:0]] = 1'b1;
              nxt_lastw = wa_ff[OFF_W-1:0];
              nxt_wseen = 1'b1;
              nxt_wa = {wa_ff[ADDR_W-1:OFF_W], wa_ff[OFF_W-1:0] + OFF_ONE};
            end
            S_RDATA: begin
              nxt_ack = 1'b0;
              {nxt_lim, nxt_cur} = {1'b0, cur_ff} + {1'b0, ADDR_ONE};
            end
            default: begin
              nxt_ack = 1'b0;
            end
          endcase
        end
      end else begin
        nxt_cnt = 4'h0;
        if (st_ff == S_RDATA) begin
          if (!sda && !lim_ff) begin
            nxt_tx = mem[cur_ff];
          end else begin
            nxt_st = S_IGN;
          end
        end
      end
    end else if (scl_fall) begin
      if (cnt_ff == ACK_BIT) begin
        nxt_oe = ack_ff;
      end else if (st_ff == S_RDATA) begin
        nxt_oe = ~tx_ff[cnt_ff[2:0]];
      end else begin
        nxt_oe = 1'b0;
      end
    end
  end

  // Protocol engine registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_ff <= S_IDLE;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      tx_ff <= 8'h00;
      cmt_ff <= 8'h00;
      oe_ff <= 1'b0;
      ack_ff <= 1'b0;
      lim_ff <= 1'b0;
      wseen_ff <= 1'b0;
      cur_ff <= '0;
      wa_ff <= '0;
      acnt_ff <= 2'h0;
      abuf_ff <= 16'h0000;
      lastw_ff <= '0;
      pv_ff <= '0;
      tmr_ff <= 32'h0;
      busy_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      tx_ff <= nxt_tx;
      cmt_ff <= nxt_cmt;
      oe_ff <= nxt_oe;
      ack_ff <= nxt_ack;
      lim_ff <= nxt_lim;
      wseen_ff <= nxt_wseen;
      cur_ff <= nxt_cur;
      wa_ff <= nxt_wa;
      acnt_ff <= nxt_acnt;
      abuf_ff <= nxt_abuf;
      lastw_ff <= nxt_lastw;
      pv_ff <= nxt_pv;
      tmr_ff <= nxt_tmr;
      busy_ff <= (nxt_st == S_WRCYC);
    end
  end

  // Page buffer and array; data bytes arrive low bit first
  always_ff @(posedge clk) begin
    if (pb_we) begin
      pbuf[wa_ff[OFF_W-1:0]] <= cep_rev8(byte_in);
    end
    if (mem_we) begin
      mem[{wa_ff[ADDR_W-1:OFF_W], cmt_ff[OFF_W-1:0]}] <= pbuf[cmt_ff[OFF_W-1:0]];
    end
  end

  // Outputs
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = oe_ff;
  assign busy = busy_ff;
  assign cur_addr = cur_ff;
endmodule

// ---- verilog/cep_prg.sv ----
// Programmer end of the two-wire program port
`timescale 1ns/10ps
module cep_prg import cep_pkg::*; (
  // System
  input wire logic clk,
  input wire logic reset,
  // Link
  cep_link_if.prg link,
  // Command
  input wire logic enable,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [LEN_W-1:0] cmd_len,
  output logic done,
  output logic error,
  // Write data
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [7:0] wr_data,
  // Read data
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data
);
  typedef enum logic [2:0] {P_IDLE, P_STA, P_BIT, P_STO, P_WGET, P_RGET} cep_pst_t;
  typedef enum logic [2:0] {PH_DEVW, PH_A2, PH_A1, PH_A0, PH_WD, PH_DEVR, PH_RD} cep_ph_t;

  cep_pst_t st_ff, nxt_st;
  cep_ph_t ph_ff, nxt_ph;
  logic [7:0] div_ff, nxt_div, tb_ff, nxt_tb, rb_ff, nxt_rb, f0_ff, nxt_f0, f1_ff, nxt_f1;
  logic [1:0] q_ff, nxt_q, fc_ff, nxt_fc;
  logic [3:0] bit_ff, nxt_bit;
  logic [LEN_W-1:0] n_ff, nxt_n, len_ff, nxt_len;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [23:0] addr24;
  logic s1_ff, s2_ff, ack_ff, nxt_ack, wr_ff, nxt_wr, scl_ff, nxt_scl, oe_ff, nxt_oe;
  logic err_ff, nxt_err, done_ff, nxt_done, seln_ff, tick, last, push, pop;

  // Two-stage synchroniser on the data line
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
    end else begin
      s1_ff <= link.cfg_serial_data_line;
      s2_ff <= s1_ff;
    end
  end

  assign tick = (div_ff == 8'(QTR_CYC - 1));
  assign last = (n_ff == len_ff - LEN_W'(1));
  assign addr24 = {PAD_ADDR, addr_ff};
  assign pop = rd_valid & rd_ready;

  // Sequencer, bit engine and read buffer next state
  always_comb begin
    nxt_st = st_ff;
    nxt_ph = ph_ff;
    nxt_div = tick ? 8'h00 : div_ff + 8'h01;
    nxt_tb = tb_ff;
    nxt_rb = rb_ff;
    nxt_q = q_ff;
    nxt_bit = bit_ff;
    nxt_n = n_ff;
    nxt_len = len_ff;
    nxt_addr = addr_ff;
    nxt_ack = ack_ff;
    nxt_wr = wr_ff;
    nxt_scl = scl_ff;
    nxt_oe = oe_ff;
    nxt_err = err_ff;
    nxt_done = 1'b0;
    push = 1'b0;
    case (st_ff)
      P_IDLE: begin
        if (cmd_valid && cmd_ready) begin
          nxt_st = P_STA;
          nxt_ph = PH_DEVW;
          nxt_tb = {DEV_SEL, 1'b0};
          nxt_wr = cmd_write;
          nxt_addr = cmd_addr;
          nxt_len = cmd_len;
          nxt_err = 1'b0;
          nxt_q = 2'h0;
        end
      end
      P_STA: begin
        if (tick) begin
          nxt_q = q_ff + 2'h1;
          case (q_ff)
            2'h0: begin
              nxt_scl = 1'b0;
              nxt_oe = 1'b0;
            end
            2'h1: nxt_scl = 1'b1;
            2'h2: nxt_oe = 1'b1;
            default: begin
              nxt_scl = 1'b0;
              nxt_st = P_BIT;
              nxt_bit = 4'h0;
            end
          endcase
        end
      end
      P_BIT: begin
        if (tick) begin
          nxt_q = q_ff + 2'h1;
          case (q_ff)
            2'h0: begin
              if (bit_ff == ACK_BIT) begin
                nxt_oe = (ph_ff == PH_RD) && !last;
              end else if (ph_ff == PH_RD) begin
                nxt_oe = 1'b0;
              end else begin
                nxt_oe = ~tb_ff[3'h7 - bit_ff[2:0]];
              end
            end
            2'h1: nxt_scl = 1'b1;
            2'h2: begin
              if (bit_ff == ACK_BIT) begin
                nxt_ack = ~s2_ff;
              end else begin
                nxt_rb = {s2_ff, rb_ff[7:1]};
              end
            end
            default: begin
              nxt_scl = 1'b0;
              nxt_bit = bit_ff + 4'h1;
              nxt_q = 2'h0;
              if (bit_ff == ACK_BIT) begin
                nxt_bit = 4'h0;
                case (ph_ff)
                  PH_DEVW, PH_DEVR: begin
                    if (!ack_ff) begin
                      nxt_st = P_STA;
                    end else if (ph_ff == PH_DEVW) begin
                      nxt_ph = PH_A2;
                      nxt_tb = addr24[23:16];
                    end else begin
                      nxt_ph = PH_RD;
                      nxt_n = '0;
                      nxt_st = P_RGET;
                    end
                  end
                  PH_A2: begin
                    nxt_ph = PH_A1;
                    nxt_tb = addr24[15:8];
                  end
                  PH_A1: begin
                    nxt_ph = PH_A0;
                    nxt_tb = addr24[7:0];
                  end
                  PH_A0: begin
                    nxt_n = '0;
                    if (wr_ff) begin
                      nxt_ph = PH_WD;
                      nxt_st = P_WGET;
                    end else begin
                      nxt_ph = PH_DEVR;
                      nxt_tb = {DEV_SEL, 1'b1};
                      nxt_st = P_STA;
                    end
                  end
                  PH_WD: begin
                    nxt_n = n_ff + LEN_W'(1);
                    nxt_st = (n_ff == LEN_W'(PAGE_BYTES - 8'h01)) ? P_STO : P_WGET;
                  end
                  default: begin
                    push = 1'b1;
                    nxt_n = n_ff + LEN_W'(1);
                    nxt_st = last ? P_STO : P_RGET;
                  end
                endcase
                if (!ack_ff && ph_ff != PH_RD && ph_ff != PH_DEVW && ph_ff != PH_DEVR) begin
                  nxt_st = P_STO;
                  nxt_err = 1'b1;
                end
              end
            end
          endcase
        end
      end
      P_STO: begin
        if (tick) begin
          nxt_q = q_ff + 2'h1;
          case (q_ff)
            2'h0: nxt_oe = 1'b1;
            2'h1: nxt_scl = 1'b1;
            2'h2: nxt_oe = 1'b0;
            default: begin
              nxt_st = P_IDLE;
              nxt_done = 1'b1;
            end
          endcase
        end
      end
      P_WGET: begin
        if (wr_valid && wr_ready) begin
          nxt_tb = cep_rev8(wr_data);
          nxt_st = P_BIT;
          nxt_q = 2'h0;
        end
      end
      default: begin
        if (fc_ff != 2'h2) begin
          nxt_st = P_BIT; // Stalls the serial clock while the buffer is full
          nxt_q = 2'h0;
        end
      end
    endcase
    // Two-entry read buffer
    nxt_f0 = f0_ff;
    nxt_f1 = f1_ff;
    nxt_fc = fc_ff;
    if (pop) begin
      nxt_f0 = f1_ff;
      nxt_fc = nxt_fc - 2'h1;
    end
    if (push) begin
      if (nxt_fc == 2'h0) begin
        nxt_f0 = rb_ff;
      end else begin
        nxt_f1 = rb_ff;
      end
      nxt_fc = nxt_fc + 2'h1;
    end
  end

  // Registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_ff <= P_IDLE;
      ph_ff <= PH_DEVW;
      div_ff <= 8'h00;
      tb_ff <= 8'h00;
      rb_ff <= 8'h00;
      q_ff <= 2'h0;
      bit_ff <= 4'h0;
      n_ff <= '0;
      len_ff <= '0;
      addr_ff <= '0;
      ack_ff <= 1'b0;
      wr_ff <= 1'b0;
      scl_ff <= 1'b1;
      oe_ff <= 1'b0;
      err_ff <= 1'b0;
      done_ff <= 1'b0;
      seln_ff <= 1'b1;
      f0_ff <= 8'h00;
      f1_ff <= 8'h00;
      fc_ff <= 2'h0;
      rd_valid <= 1'b0;
      cmd_ready <= 1'b0;
      wr_ready <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      ph_ff <= nxt_ph;
      div_ff <= nxt_div;
      tb_ff <= nxt_tb;
      rb_ff <= nxt_rb;
      q_ff <= nxt_q;
      bit_ff <= nxt_bit;
      n_ff <= nxt_n;
      len_ff <= nxt_len;
      addr_ff <= nxt_addr;
      ack_ff <= nxt_ack;
      wr_ff <= nxt_wr;
      scl_ff <= nxt_scl;
      oe_ff <= nxt_oe;
      err_ff <= nxt_err;
      done_ff <= nxt_done;
      seln_ff <= ~enable;
      f0_ff <= nxt_f0;
      f1_ff <= nxt_f1;
      fc_ff <= nxt_fc;
      rd_valid <= (nxt_fc != 2'h0);
      cmd_ready <= (nxt_st == P_IDLE) && enable && !(cmd_valid && cmd_ready);
      wr_ready <= (nxt_st == P_WGET) && !(wr_valid && wr_ready);
    end
  end

  // Outputs
  assign link.program_mode_select_n = seln_ff;
  assign link.cfg_serial_clock_line = scl_ff;
  assign link.prg_sda_o = 1'b0;
  assign link.prg_sda_oe = oe_ff;
  assign done = done_ff;
  assign error = err_ff;
  assign rd_data = f0_ff;
endmodule

// ---- tb/cep_link_asserts.sv ----
// Checker for the two-wire link between programmer and device
`timescale 1ns/10ps
module cep_link_asserts import cep_pkg::*; (
  // System
  input wire logic clk,
  input wire logic reset,
  // Link
  input wire logic program_mode_select_n,
  input wire logic cfg_serial_clock_line,
  input wire logic prg_sda_o,
  input wire logic prg_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic cfg_serial_data_line
);
  logic scl_ff, nxt_scl, sda_ff, nxt_sda, first_ff, nxt_first;
  logic [3:0] bits_ff, nxt_bits;
  logic [6:0] sh_ff, nxt_sh;
  logic start, stop, rise;

  // Line events seen against the previous cycle
  assign start = scl_ff && cfg_serial_clock_line && sda_ff && !cfg_serial_data_line;
  assign stop = scl_ff && cfg_serial_clock_line && !sda_ff && cfg_serial_data_line;
  assign rise = !scl_ff && cfg_serial_clock_line;

  // Bit count and shift of the first byte after a start
  always_comb begin
    nxt_scl = cfg_serial_clock_line;
    nxt_sda = cfg_serial_data_line;
    nxt_bits = bits_ff;
    nxt_first = first_ff;
    nxt_sh = sh_ff;
    if (start) begin
      nxt_bits = 4'h0;
      nxt_first = 1'b1;
    end else if (rise && bits_ff == 4'h8) begin
      nxt_bits = 4'h0;
      nxt_first = 1'b0;
    end else if (rise) begin
      nxt_bits = bits_ff + 4'h1;
      nxt_sh = {sh_ff[5:0], cfg_serial_data_line};
    end
  end

  // Helper registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
      first_ff <= 1'b0;
      bits_ff <= 4'h0;
      sh_ff <= 7'h00;
    end else begin
      scl_ff <= nxt_scl;
      sda_ff <= nxt_sda;
      first_ff <= nxt_first;
      bits_ff <= nxt_bits;
      sh_ff <= nxt_sh;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Start holds data low until the clock falls
  sequence s_start;
    start;
  endsequence
  sequence s_low_to_clk;
    !cfg_serial_data_line throughout (##[1:8] !cfg_serial_clock_line);
  endsequence
  sequence s_stop;
    stop;
  endsequence

  a_prg_drain_only: assert property (prg_sda_oe |-> !prg_sda_o)
    else $error("programmer drives data line high");
  a_dev_drain_only: assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("device drives data line high");
  a_dev_change_low: assert property ($changed(dev_sda_oe) |-> !cfg_serial_clock_line)
    else $error("device data changed with clock high");
  a_dev_quiet_off: assert property (program_mode_select_n [*4] |-> !dev_sda_oe)
    else $error("device drives line outside programming mode");
  a_idle_lines_high: assert property (program_mode_select_n |-> cfg_serial_clock_line && cfg_serial_data_line)
    else $error("link not idle while unselected");
  a_start_then_low: assert property (s_start |-> s_low_to_clk)
    else $error("start not followed by clock low");
  a_stop_clock_high: assert property (s_stop |-> cfg_serial_clock_line [*4])
    else $error("clock moved right after stop");
  a_clock_high_min: assert property ($rose(cfg_serial_clock_line) |-> cfg_serial_clock_line [*4])
    else $error("serial clock high phase too short");
  a_dev_code_msb: assert property (rise && first_ff && bits_ff == 4'h7 |-> sh_ff == DEV_SEL)
    else $error("device byte not sent most significant first");
endmodule

// ---- tb/test_config_eeprom_serial_program_port.sv ----
// Bench joining programmer and device ends over one link
`timescale 1ns/10ps
module test_config_eeprom_serial_program_port import cep_pkg::*; ;
  logic clk = 1'b0, reset = 1'b1, enable = 1'b0, rd_ready = 1'b0;
  logic cmd_valid = 1'b0, cmd_write = 1'b0, wr_valid = 1'b0;
  logic [ADDR_W-1:0] cmd_addr = '0;
  logic [LEN_W-1:0] cmd_len = '0;
  logic [7:0] wr_data = 8'h00;
  logic cmd_ready, done, error, wr_ready, rd_valid, busy;
  logic [7:0] rd_data;
  logic [ADDR_W-1:0] cur_addr;
  int fail_count = 0, checks_done = 0, cyc = 0;
  // Wire monitor state
  logic ps = 1'b1, pd = 1'b1;
  int bi = 0, fi = 0, n_start = 0;
  logic [7:0] fm [10];
  logic [7:0] fl [10];
  logic fa [10];

  cep_link_if link();
  cep_dev #(.WR_CYCLES(200)) i_cep_dev (.clk(clk), .reset(reset), .link(link), .busy(busy),
    .cur_addr(cur_addr));
  cep_prg i_cep_prg (.clk(clk), .reset(reset), .link(link), .enable(enable),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_len(cmd_len), .done(done), .error(error), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));
  cep_link_asserts i_cep_link_asserts (.clk(clk), .reset(reset),
    .program_mode_select_n(link.program_mode_select_n),
    .cfg_serial_clock_line(link.cfg_serial_clock_line), .prg_sda_o(link.prg_sda_o),
    .prg_sda_oe(link.prg_sda_oe), .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe),
    .cfg_serial_data_line(link.cfg_serial_data_line));

  // System clock, 20 ns period
  always #10 clk = ~clk;

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Cycle ceiling against a hung link
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      close_out;
    end
  end

  // Captures bytes on the wire after each start
  always @(negedge clk) begin
    if (ps && link.cfg_serial_clock_line && pd && !link.cfg_serial_data_line) begin
      bi = 0;
      fi = 0;
      n_start++;
    end else if (!ps && link.cfg_serial_clock_line && fi < 10) begin
      if (bi < 8) begin
        fm[fi] = {fm[fi][6:0], link.cfg_serial_data_line};
        fl[fi] = {link.cfg_serial_data_line, fl[fi][7:1]};
        bi++;
      end else begin
        fa[fi] = link.cfg_serial_data_line;
        bi = 0;
        fi++;
      end
    end
    ps = link.cfg_serial_clock_line;
    pd = link.cfg_serial_data_line;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic sig(input int w);
    case (w)
      0: return cmd_ready;
      1: return wr_ready;
      2: return done;
      default: return rd_valid;
    endcase
  endfunction

  // Waits until the chosen flag is high just after an edge
  task automatic wait_for(input int w);
    while (sig(w) !== 1'b1) begin
      @(posedge clk);
      #1;
    end
  endtask

  task automatic run_cmd(input logic w, input logic [ADDR_W-1:0] a, input logic [LEN_W-1:0] n);
    cmd_write = w;
    cmd_addr = a;
    cmd_len = n;
    cmd_valid = 1'b1;
    wait_for(0);
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
  endtask

  // Page patterns: page one written from offset 5, page two from 0
  function automatic logic [7:0] dat(input logic s, input logic [6:0] k);
    return s ? 8'h3c + {1'b0, k} : 8'ha0 ^ {1'b0, k};
  endfunction
  function automatic logic [7:0] exp_at(input logic [ADDR_W-1:0] a);
    return a[8] ? dat(1'b1, a[6:0]) : dat(1'b0, a[6:0] - 7'h05);
  endfunction

  task automatic wr_page(input logic s, input logic [ADDR_W-1:0] a);
    run_cmd(1'b1, a, 18'h00080);
    for (int k = 0; k < 128; k++) begin
      wr_data = dat(s, 7'(k));
      wr_valid = 1'b1;
      wait_for(1);
      @(posedge clk);
      #1;
    end
    wr_valid = 1'b0;
    wait_for(2);
  endtask

  // Reads with the receiver stalled first so the buffer fills
  task automatic rd_run(input logic [ADDR_W-1:0] a, input logic [LEN_W-1:0] n, input int stall);
    run_cmd(1'b0, a, n);
    wait_for(3);
    repeat (stall) begin
      @(posedge clk);
      #1;
    end
    if (stall > 0) begin
      chk("stall_scl", 32'h0, 32'(link.cfg_serial_clock_line));
    end
    rd_ready = 1'b1;
    for (int j = 0; j < n; j++) begin
      wait_for(3);
      chk("rd_data", 32'(exp_at(a + 17'(j))), 32'(rd_data));
      @(posedge clk);
      #1;
    end
    rd_ready = 1'b0;
    wait_for(2);
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    #1;
    reset = 1'b0;
    repeat (20) @(posedge clk);
    #1;
    chk("cmd_ready", 32'h0, 32'(cmd_ready));
    chk("select_n", 32'h1, 32'(link.program_mode_select_n));
    enable = 1'b1;
    $display("test unselected done");
    wr_page(1'b0, 17'h00085);
    chk("dev_byte", 32'ha0, 32'(fm[0]));
    chk("addr_hi", 32'h00, 32'(fm[1]));
    chk("addr_lo", 32'h85, 32'(fm[3]));
    chk("data0", 32'ha0, 32'(fl[4]));
    chk("data1", 32'ha1, 32'(fl[5]));
    chk("acks", 32'h0, 32'({fa[0], fa[1], fa[2], fa[3], fa[4]}));
    chk("addr_wrap", 32'h00085, 32'(cur_addr));
    repeat (8) @(posedge clk);
    #1;
    chk("busy", 32'h1, 32'(busy));
    chk("select_busy", 32'h0, 32'(link.program_mode_select_n));
    $display("test wrap write done");
    n_start = 0;
    wr_page(1'b1, 17'h00100);
    chk("polls", 32'h1, 32'(n_start > 1));
    chk("dev_ack", 32'h0, 32'(fa[0]));
    chk("addr_next_page", 32'h00180, 32'(cur_addr));
    chk("error", 32'h0, 32'(error));
    $display("test polled write done");
    rd_run(17'h000fc, 18'h00008, 600);
    chk("rd_dev_byte", 32'ha1, 32'(fm[0]));
    chk("rd_lsb_first", 32'(exp_at(17'h000fc)), 32'(fl[1]));
    chk("rd_mid_ack", 32'h0, 32'(fa[4]));
    chk("rd_last_nack", 32'h1, 32'(fa[8]));
    chk("addr_read", 32'h00104, 32'(cur_addr));
    $display("test sequential read done");
    rd_run(17'h00084, 18'h00001, 0);
    chk("single_nack", 32'h1, 32'(fa[1]));
    $display("test single read done");
    close_out;
  end
endmodule
